// ===== src/tsr_pkg.sv
// constants shared by the temperature sensor register bank
package tsr_pkg;

   // ************************************************************
   // register pointer and register selection
   // ************************************************************
   localparam int PTR_WIDTH = 8;
   localparam int REG_WIDTH = 16;
   localparam int SEL_WIDTH = 2;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [1:0] SEL_TEMPERATURE_RESULT = 2'h0;
   localparam logic [1:0] SEL_SENSOR_CONFIGURATION = 2'h1;
   localparam logic [1:0] SEL_LOWER_LIMIT = 2'h2;
   localparam logic [1:0] SEL_UPPER_LIMIT = 2'h3;

   // ************************************************************
   // configuration layout and reset values
   // ************************************************************
   localparam logic [15:0] CFG_RESET = 16'h40A0;
   localparam logic [15:0] CFG_WRITE_MASK = 16'h9FC0;
   localparam int CFG_RATE_LSB = 6;
   localparam int CFG_SLEEP_BIT = 8;
   localparam logic [15:0] TEMP_RESET = 16'h0000;
   localparam logic [15:0] LOWER_LIMIT_RESET = 16'h0000;
   localparam logic [15:0] UPPER_LIMIT_RESET = 16'h0000;

   // ************************************************************
   // conversion rates: period per setting, clock 250 mhz
   // ************************************************************
   localparam logic [1:0] RATE_QUARTER = 2'h0;
   localparam logic [1:0] RATE_ONE = 2'h1;
   localparam logic [1:0] RATE_FOUR = 2'h2;
   localparam logic [1:0] RATE_EIGHT = 2'h3;
   localparam int CLK_KHZ = 250000;
   localparam int PERIOD_QUARTER_MS = 4000;
   localparam int PERIOD_ONE_MS = 1000;
   localparam int PERIOD_FOUR_MS = 250;
   localparam int PERIOD_EIGHT_MS = 125;
   localparam int CYC_QUARTER = PERIOD_QUARTER_MS * CLK_KHZ;
   localparam int CYC_ONE = PERIOD_ONE_MS * CLK_KHZ;
   localparam int CYC_FOUR = PERIOD_FOUR_MS * CLK_KHZ;
   localparam int CYC_EIGHT = PERIOD_EIGHT_MS * CLK_KHZ;
   localparam int CNT_WIDTH = 30;
   localparam logic [29:0] CNT_ZERO = 30'h0000_0000;

endpackage : tsr_pkg

// ===== src/tsr_rate_timer.sv
// conversion start timer stepping at the selected conversion rate
`timescale 1ns/1ns
module tsr_rate_timer
   import tsr_pkg::*;
#(
   parameter int unsigned PERIOD_QUARTER = CYC_QUARTER,
   parameter int unsigned PERIOD_ONE = CYC_ONE,
   parameter int unsigned PERIOD_FOUR = CYC_FOUR,
   parameter int unsigned PERIOD_EIGHT = CYC_EIGHT
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [1:0] rate_sel_i,
   input wire logic run_i,
   output logic tick_o
);

   logic [29:0] count_reg;
   logic [29:0] count_next;
   logic tick_reg;
   logic [29:0] limit;
   logic at_limit;

   // ************************************************************
   // period selection
   // ************************************************************
   // rate change takes effect at once; a shorter limit ends the wait
   assign limit = (rate_sel_i == RATE_QUARTER) ? 30'(PERIOD_QUARTER - 1) :
                  (rate_sel_i == RATE_ONE) ? 30'(PERIOD_ONE - 1) :
                  (rate_sel_i == RATE_FOUR) ? 30'(PERIOD_FOUR - 1) :
                  30'(PERIOD_EIGHT - 1);
   assign at_limit = run_i && (count_reg >= limit);
   assign count_next = !run_i ? CNT_ZERO :
                       at_limit ? CNT_ZERO : count_reg + 30'h0000_0001;

   // counter and registered tick
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= CNT_ZERO;
         tick_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg <= at_limit;
      end
   end

   assign tick_o = tick_reg;

endmodule : tsr_rate_timer

// ===== src/tsr_register_bank.sv
// register pointer and register bank of the temperature sensor
//
// Operation
// - eight-bit pointer, two low bits writable, both zero after reset
// - pointer bits 2 to 7 read zero and ignore writes
// - low pointer bits select result, configuration, lower or upper limit
// - result register ignores writes; the other three are read/write
// - conversion rate defaults to four per second; field picks four rates
//
// Timing
// pointer write: pointer and read word move one edge later
// register write: lands on the pointer held before that edge
// pointer and register write in one cycle: old pointer wins
// result load: read word follows on the same edge when selected
// conversion tick: one cycle high per period, held off in sleep
//
// Reset
// pointer 0x00 selects the result, which reads 0x0000
// configuration comes up at four conversions a second
//
// Limitations
// only the two pointer bits are real flops; the rest is wiring
// alert, interrupt and single-shot logic sit outside this block
// rate change resizes the running wait instead of finishing it; a shorter period cuts it short
`timescale 1ns/1ns
module tsr_register_bank
   import tsr_pkg::*;
#(
   parameter int unsigned PERIOD_QUARTER = CYC_QUARTER,
   parameter int unsigned PERIOD_ONE = CYC_ONE,
   parameter int unsigned PERIOD_FOUR = CYC_FOUR,
   parameter int unsigned PERIOD_EIGHT = CYC_EIGHT
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // pointer write from the serial interface
   input wire logic ptr_wr_i,
   input wire logic [7:0] ptr_wdata_i,
   // register write to the selected register
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   // new conversion result from the signal processor
   input wire logic temp_valid_i,
   input wire logic [15:0] temp_value_i,
   // pointer readback and the word of the selected register
   output logic [7:0] ptr_o,
   output logic [15:0] rd_data_o,
   // register contents and rate field for the sensor core
   output logic [15:0] config_o,
   output logic [15:0] lower_limit_o,
   output logic [15:0] upper_limit_o,
   output logic [1:0] conversion_rate_select_o,
   // one clock high at every conversion start
   output logic conv_start_o
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [1:0] sel_reg;
   logic [1:0] sel_next;
   logic [15:0] temperature_result_reg;
   logic [15:0] temperature_result_next;
   logic [15:0] sensor_configuration_reg;
   logic [15:0] sensor_configuration_next;
   logic [15:0] lower_limit_reg;
   logic [15:0] lower_limit_next;
   logic [15:0] upper_limit_reg;
   logic [15:0] upper_limit_next;
   logic [15:0] rd_data_reg;
   logic [15:0] rd_data_next;

   // ************************************************************
   // decoding
   // ************************************************************
   // one-hot decode of a selector, used for writes and reads
   function automatic logic [3:0] sel_decode(input logic [1:0] sel);
      logic [3:0] hot;
      hot = 4'h0;
      hot[sel] = 1'b1;
      return hot;
   endfunction : sel_decode

   logic [3:0] wr_hit;
   logic [3:0] rd_hit;
   logic cfg_wr;
   logic lower_wr;
   logic upper_wr;
   logic [1:0] rate_field;
   logic sleep_on;
   logic tick;

   // route by low pointer bits
   // writes decode the pointer held before the edge, so a pointer
   // write in the same cycle cannot redirect the data word
   assign wr_hit = reg_wr_i ? sel_decode(sel_reg) : 4'h0;

   // per-register write strobes; the result register gets none
   assign cfg_wr = wr_hit[SEL_SENSOR_CONFIGURATION];
   assign lower_wr = wr_hit[SEL_LOWER_LIMIT];
   assign upper_wr = wr_hit[SEL_UPPER_LIMIT];

   // only two pointer bits are stored
   assign sel_next = ptr_wr_i ? ptr_wdata_i[1:0] : sel_reg;

   // result takes converter data only, host writes ignored
   assign temperature_result_next = temp_valid_i ? temp_value_i :
                                    temperature_result_reg;

   // writable configuration bits only; read-only bits keep resets
   assign sensor_configuration_next =
      cfg_wr ?
      ((reg_wdata_i & CFG_WRITE_MASK) |
       (sensor_configuration_reg & ~CFG_WRITE_MASK)) :
      sensor_configuration_reg;

   assign lower_limit_next = lower_wr ? reg_wdata_i :
                             lower_limit_reg;
   assign upper_limit_next = upper_wr ? reg_wdata_i :
                             upper_limit_reg;

   // read mux follows the pointer as it stands after this cycle,
   // so data is ready one edge after a pointer write; it also
   // takes next values, so a write shows up on the same edge
   assign rd_hit = sel_decode(sel_next);
   assign rd_data_next =
      ({16{rd_hit[SEL_TEMPERATURE_RESULT]}} & temperature_result_next) |
      ({16{rd_hit[SEL_SENSOR_CONFIGURATION]}} & sensor_configuration_next) |
      ({16{rd_hit[SEL_LOWER_LIMIT]}} & lower_limit_next) |
      ({16{rd_hit[SEL_UPPER_LIMIT]}} & upper_limit_next);

   // ************************************************************
   // registers
   // ************************************************************
   // pointer clears on reset
   // only bits 1:0 are stored; bits 7:2 are constant zero wiring
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_reg <= PTR_RESET[1:0];
      end else begin
         sel_reg <= sel_next;
      end
   end

   // result register, loaded only by the converter
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         temperature_result_reg <= TEMP_RESET;
      end else begin
         temperature_result_reg <= temperature_result_next;
      end
   end

   // configuration reset gives four conversions a second
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sensor_configuration_reg <= CFG_RESET;
      end else begin
         sensor_configuration_reg <= sensor_configuration_next;
      end
   end

   // lower limit, plain read/write word
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lower_limit_reg <= LOWER_LIMIT_RESET;
      end else begin
         lower_limit_reg <= lower_limit_next;
      end
   end

   // upper limit, plain read/write word
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upper_limit_reg <= UPPER_LIMIT_RESET;
      end else begin
         upper_limit_reg <= upper_limit_next;
      end
   end

   // read data is a flop so the serial side sees a stable word
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_reg <= TEMP_RESET;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ************************************************************
   // conversion timing
   // ************************************************************
   // sleep clears the timer, so waking waits a full period
   // before the first start; rate changes act at once
   assign sleep_on = sensor_configuration_reg[CFG_SLEEP_BIT];
   assign rate_field = sensor_configuration_reg[CFG_RATE_LSB +: 2];

   // rate field steers the conversion period
   tsr_rate_timer #(
      .PERIOD_QUARTER(PERIOD_QUARTER),
      .PERIOD_ONE(PERIOD_ONE),
      .PERIOD_FOUR(PERIOD_FOUR),
      .PERIOD_EIGHT(PERIOD_EIGHT)
   ) u_rate_timer (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .rate_sel_i(rate_field),
      .run_i(!sleep_on),
      .tick_o(tick)
   );

   // ************************************************************
   // outputs, all from flops
   // ************************************************************
   // upper pointer bits always read zero
   assign ptr_o = {6'h00, sel_reg};
   assign rd_data_o = rd_data_reg;
   assign config_o = sensor_configuration_reg;
   assign lower_limit_o = lower_limit_reg;
   assign upper_limit_o = upper_limit_reg;
   assign conversion_rate_select_o = rate_field;
   assign conv_start_o = tick;

endmodule : tsr_register_bank

// ===== tb/tsr_host_model.sv
// host model driving pointer, register and result strobes
`timescale 1ns/1ns
module tsr_host_model (
   input wire logic clk_sys_i,
   output logic ptr_wr_o,
   output logic [7:0] ptr_wdata_o,
   output logic reg_wr_o,
   output logic [15:0] reg_wdata_o,
   output logic temp_valid_o,
   output logic [15:0] temp_value_o
);
   // idle strobes from time zero
   initial begin
      {ptr_wr_o, reg_wr_o, temp_valid_o} = 3'h0;
      {ptr_wdata_o, reg_wdata_o, temp_value_o} = {8'h00, 16'h0000, 16'h0000};
   end
   task set_ptr(input logic [7:0] v);
      @(posedge clk_sys_i) #1 {ptr_wr_o, ptr_wdata_o} = {1'b1, v};
      @(posedge clk_sys_i) #1 {ptr_wr_o, ptr_wdata_o} = {1'b0, ~v};
   endtask : set_ptr
   // released data flips so stale values never pass
   task wr_reg(input logic [15:0] v);
      @(posedge clk_sys_i) #1 {reg_wr_o, reg_wdata_o} = {1'b1, v};
      @(posedge clk_sys_i) #1 {reg_wr_o, reg_wdata_o} = {1'b0, ~v};
   endtask : wr_reg
   task load_temp(input logic [15:0] v);
      @(posedge clk_sys_i) #1 {temp_valid_o, temp_value_o} = {1'b1, v};
      @(posedge clk_sys_i) #1 {temp_valid_o, temp_value_o} = {1'b0, ~v};
   endtask : load_temp
endmodule : tsr_host_model

// ===== tb/tsr_register_bank_properties.sv
// pointer and register bank checker, bound to the bank
`timescale 1ns/1ns
module tsr_register_bank_properties
   import tsr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ptr_wr_i,
   input wire logic [7:0] ptr_wdata_i,
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic temp_valid_i,
   input wire logic [15:0] temp_value_i,
   input wire logic [7:0] ptr_o,
   input wire logic [15:0] rd_data_o,
   input wire logic [15:0] config_o,
   input wire logic [15:0] lower_limit_o,
   input wire logic [15:0] upper_limit_o,
   input wire logic [1:0] conversion_rate_select_o,
   input wire logic conv_start_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [1:0] sel = ptr_o[1:0];
   property p_load; ptr_wr_i |=> sel == $past(ptr_wdata_i[1:0]); endproperty
   a_load: assert property (p_load) else $error("pointer not loaded");
   property p_upper_bits; ptr_o[7:2] == 6'h00; endproperty
   a_upper_bits: assert property (p_upper_bits) else $error("ptr high");
   property p_route; sel != 2'h0 |-> rd_data_o == (sel == 2'h1 ? config_o
      : sel == 2'h2 ? lower_limit_o : upper_limit_o); endproperty
   a_route: assert property (p_route) else $error("bad read route");
   property p_lower; reg_wr_i && sel == 2'h2
      |=> lower_limit_o == $past(reg_wdata_i); endproperty
   a_lower: assert property (p_lower) else $error("lower not written");
   property p_upper; reg_wr_i && sel == 2'h3
      |=> upper_limit_o == $past(reg_wdata_i); endproperty
   a_upper: assert property (p_upper) else $error("upper not written");
   property p_cfg; reg_wr_i && sel == 2'h1 |=> config_o ==
      (($past(reg_wdata_i) & CFG_WRITE_MASK) | 16'h4020); endproperty
   a_cfg: assert property (p_cfg) else $error("config write wrong");
   property p_ro; reg_wr_i && sel == 2'h0 && !ptr_wr_i && !temp_valid_i
      |=> $stable(rd_data_o) && $stable(config_o); endproperty
   a_ro: assert property (p_ro) else $error("result was written");
   property p_rate; conversion_rate_select_o == config_o[7:6]; endproperty
   a_rate: assert property (p_rate) else $error("rate field mismatch");
   property p_hold; !ptr_wr_i |=> $stable(ptr_o); endproperty
   a_hold: assert property (p_hold) else $error("pointer drifted");
   property p_result; temp_valid_i && !ptr_wr_i && sel == 2'h0
      |=> rd_data_o == $past(temp_value_i); endproperty
   a_result: assert property (p_result) else $error("result not shown");
   property p_tick; conv_start_o |=> !conv_start_o; endproperty
   a_tick: assert property (p_tick) else $error("start pulse too long");
   c_cfg: cover property (reg_wr_i && sel == 2'h1);
   c_tick: cover property (conv_start_o);
   c_temp: cover property (temp_valid_i && sel == 2'h0);
endmodule : tsr_register_bank_properties
bind tsr_register_bank tsr_register_bank_properties chk (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ptr_wr_i(ptr_wr_i),
   .ptr_wdata_i(ptr_wdata_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .temp_valid_i(temp_valid_i), .temp_value_i(temp_value_i), .ptr_o(ptr_o),
   .rd_data_o(rd_data_o), .config_o(config_o), .lower_limit_o(lower_limit_o),
   .upper_limit_o(upper_limit_o), .conv_start_o(conv_start_o),
   .conversion_rate_select_o(conversion_rate_select_o));

// ===== tb/tsr_register_bank_tb.sv
// self-checking bench for the temperature sensor register bank
`timescale 1ns/1ns
module tsr_register_bank_tb;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic pw, rw, tv, cs;
   logic [7:0] pd, ptr;
   logic [15:0] rwd, temperature_result, rd, cfg, lo, hi;
   logic [1:0] rate;
   int errors = 0;
   int total_checks = 0;
   int n;
   // short periods keep the tick checks fast
   localparam int unsigned P_QUARTER = 40;
   localparam int unsigned P_ONE = 20;
   localparam int unsigned P_FOUR = 10;
   localparam int unsigned P_EIGHT = 5;
   // pointer, write data, expected readback
   logic [39:0] rows [5] = '{40'hFD_FFFF_DFE0, 40'h02_1234_1234,
      40'hFF_A5A5_A5A5, 40'h00_BEEF_0000, 40'h01_0000_4020};
   logic [15:0] per [4] = '{16'(P_QUARTER), 16'(P_ONE), 16'(P_FOUR),
      16'(P_EIGHT)};
   always #2 clk_sys_i = ~clk_sys_i;
   tsr_host_model host (.clk_sys_i(clk_sys_i), .ptr_wr_o(pw),
      .ptr_wdata_o(pd), .reg_wr_o(rw), .reg_wdata_o(rwd),
      .temp_valid_o(tv), .temp_value_o(temperature_result));
   tsr_register_bank #(.PERIOD_QUARTER(P_QUARTER), .PERIOD_ONE(P_ONE),
      .PERIOD_FOUR(P_FOUR), .PERIOD_EIGHT(P_EIGHT)) dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ptr_wr_i(pw),
      .ptr_wdata_i(pd), .reg_wr_i(rw),
      .reg_wdata_i(rwd), .temp_valid_i(tv), .temp_value_i(temperature_result),
      .ptr_o(ptr), .rd_data_o(rd), .config_o(cfg), .lower_limit_o(lo),
      .upper_limit_o(hi), .conversion_rate_select_o(rate),
      .conv_start_o(cs));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // cycles until the next tick, capped at 100
   task gap(output int c);
      c = 0;
      do begin
         @(posedge clk_sys_i) #1;
         c++;
      end while (cs !== 1'b1 && c < 100);
   endtask : gap
   task test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(posedge clk_sys_i);
      #1 rst_n_i = 1'b1;
      gap(n);
      chk(16'(n), 16'(P_FOUR));
      chk({14'h0000, rate}, 16'h0002);
      chk({8'h00, ptr}, 16'h0000);
      chk(cfg, 16'h40A0);
      foreach (rows[i]) begin
         host.set_ptr(rows[i][39:32]);
         chk({8'h00, ptr}, {14'h0000, rows[i][33:32]});
         host.wr_reg(rows[i][31:16]);
         chk(rd, rows[i][15:0]);
      end
      chk(lo, 16'h1234);
      chk(hi, 16'hA5A5);
      // every rate setting, pointer still on configuration
      for (int r = 0; r < 4; r++) begin
         host.wr_reg({8'h00, r[1:0], 6'h00});
         gap(n);
         gap(n);
         chk(16'(n), per[r]);
      end
      chk(rd, 16'h40E0);
      // row 3 holds pointer zero and a write the result must refuse
      host.set_ptr(rows[3][39:32]);
      host.load_temp(16'h1A2B);
      chk(rd, 16'h1A2B);
      host.wr_reg(rows[3][31:16]);
      chk(rd, 16'h1A2B);
      rst_n_i = 1'b0;
      @(posedge clk_sys_i) #1;
      chk({8'h00, ptr}, 16'h0000);
      chk(hi, 16'h0000);
      rst_n_i = 1'b1;
      // after a mid-run reset the timer starts its first period again
      gap(n);
      chk(16'(n), 16'(P_FOUR));
      chk(rd, 16'h0000);
      chk(cfg, 16'h40A0);
      test_done();
   end
   // hang guard, well past the expected run length
   initial begin
      #20000;
      errors++;
      test_done();
   end
endmodule : tsr_register_bank_tb
